//--- design/adio_axis.sv
`default_nettype none
module adio_axis
  import adio_pkg::*;
#(
  parameter int unsigned SCAN_CYC = SCAN_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       startup_ok,
  input  wire logic       machine_data_valid,
  input  wire logic       cpu_stopped,
  input  wire logic       cmd_output_disable_fitted,
  input  wire logic       limit_polarity,
  input  wire logic       travel_start_limit_input,
  input  wire logic       travel_end_limit_input,
  input  wire logic       precontact_input,
  input  wire logic       incremental_variant,
  input  wire logic       ext_start_stop_input,
  input  wire logic [3:0] mode,
  input  wire logic [2:0] cmd,
  input  wire logic       job_traversing,
  input  wire logic       job_valid,
  input  wire logic       motion_dir_pos,
  input  wire logic       motion_active,
  input  wire logic       setpoint_at_target,
  input  wire logic       in_standstill_window,
  input  wire logic       soft_limit_reached,
  output logic            axis_ready_output,
  output logic            in_position_output,
  output logic            in_position_status,
  output logic            job_execute,
  output logic            brake_max_decel,
  output logic            brake_soft,
  output logic            job_abort,
  output logic            program_abort,
  output logic            follow_mode_end,
  output logic            waiting_ext_start,
  output logic            err_limit_start,
  output logic            err_limit_end,
  output logic            err_ext_stop,
  output logic            err_inadmissible,
  output logic            block_neg_dir,
  output logic            block_pos_dir
);
  initial begin
    if (SCAN_CYC < 2 || SCAN_CYC >= (1 << SCAN_W)) $error("adio_axis: SCAN_CYC out of range");
  end

  // scan divider
  logic [SCAN_W-1:0] scan_cnt_q;
  logic              scan_tick;
  assign scan_tick = (scan_cnt_q == SCAN_W'(SCAN_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) scan_cnt_q <= '0;
    else if (scan_tick) scan_cnt_q <= '0;
    else scan_cnt_q <= scan_cnt_q + SCAN_W'(1);
  end

  // two-flop synchronisers for the four pins
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] samp_q;
  logic [3:0] prev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {precontact_input, ext_start_stop_input, travel_end_limit_input, travel_start_limit_input};
      sync2_q <= sync1_q;
    end
  end

  // once-per-scan samples
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= '0;
      prev_q <= '0;
    end else if (scan_tick) begin
      samp_q <= sync2_q;
      prev_q <= samp_q;
    end
  end

  logic sample_pulse_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sample_pulse_q <= 1'b0;
    else sample_pulse_q <= scan_tick;
  end

  // normally closed contact reads low when tripped
  function automatic logic tripped(input logic lvl, input logic pol);
    tripped = (pol == POL_NC) ? ~lvl : lvl;
  endfunction

  logic neg_lim;
  logic pos_lim;
  logic neg_lim_prev;
  logic pos_lim_prev;
  assign neg_lim      = tripped(samp_q[0], limit_polarity);
  assign pos_lim      = tripped(samp_q[1], limit_polarity);
  assign neg_lim_prev = tripped(prev_q[0], limit_polarity);
  assign pos_lim_prev = tripped(prev_q[1], limit_polarity);

  logic ss_rise;
  logic ss_fall;
  logic ss_level;
  logic pre_rise;
  assign ss_level = samp_q[2];
  assign ss_rise  = sample_pulse_q & samp_q[2] & ~prev_q[2];
  assign ss_fall  = sample_pulse_q & ~samp_q[2] & prev_q[2];
  assign pre_rise = sample_pulse_q & samp_q[3] & ~prev_q[3];

  logic following;
  assign following = (mode == MODE_FOLLOW);

  // limit evaluation independent of axis type
  logic lim_watch;
  logic trip_neg;
  logic trip_pos;
  assign lim_watch = motion_active | following;
  assign trip_neg  = sample_pulse_q & lim_watch & neg_lim & ~motion_dir_pos;
  assign trip_pos  = sample_pulse_q & lim_watch & pos_lim & motion_dir_pos;

  // direction blocking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_neg_dir <= 1'b0;
      block_pos_dir <= 1'b0;
    end else begin
      if (trip_neg) block_neg_dir <= 1'b1;
      else if (sample_pulse_q && ((neg_lim_prev && !neg_lim && motion_dir_pos) || (pos_lim && !motion_dir_pos)))
        block_neg_dir <= 1'b0;
      else if (pre_rise && incremental_variant) block_neg_dir <= 1'b0;
      if (trip_pos) block_pos_dir <= 1'b1;
      else if (sample_pulse_q && ((pos_lim_prev && !pos_lim && !motion_dir_pos) || (neg_lim && motion_dir_pos)))
        block_pos_dir <= 1'b0;
      else if (pre_rise && incremental_variant) block_pos_dir <= 1'b0;
    end
  end

  // held job state machine
  adio_state_t state_q;
  logic        in_pos_d;
  logic        stop_armed_q;
  logic        ext_stop_evt;
  logic        lim_stop_evt;
  assign in_pos_d     = setpoint_at_target & in_standstill_window;
  assign ext_stop_evt = ss_rise & (state_q == ADIO_RUN) & motion_active & ~following;
  assign lim_stop_evt = (trip_neg | trip_pos) & ~following;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= ADIO_IDLE;
      job_execute      <= 1'b0;
      waiting_ext_start <= 1'b0;
      err_inadmissible <= 1'b0;
      stop_armed_q     <= 1'b0;
    end else begin
      job_execute      <= 1'b0;
      err_inadmissible <= 1'b0;
      case (state_q)
        ADIO_IDLE: begin
          if (cmd == CMD_START && job_traversing && job_valid) begin
            if (ss_level) begin
              state_q           <= ADIO_WAIT;
              waiting_ext_start <= (mode != MODE_SINGLE);
            end else begin
              state_q     <= ADIO_RUN;
              job_execute <= 1'b1;
            end
          end
        end
        ADIO_WAIT: begin
          if (mode == MODE_SINGLE && cmd == CMD_ENTER) waiting_ext_start <= 1'b1;
          if (cmd == CMD_STOP) begin
            state_q           <= ADIO_IDLE;
            waiting_ext_start <= 1'b0;
          end else if (cmd == CMD_START) begin
            waiting_ext_start <= 1'b0;
            state_q           <= ADIO_IDLE;
          end else if (cmd == CMD_OTHER) begin
            err_inadmissible <= 1'b1;
          end else if (ss_fall && (waiting_ext_start || mode != MODE_SINGLE)) begin
            state_q           <= ADIO_RUN;
            waiting_ext_start <= 1'b0;
            job_execute       <= 1'b1;
          end
        end
        ADIO_RUN: begin
          if (ext_stop_evt || lim_stop_evt || cmd == CMD_STOP) state_q <= ADIO_IDLE;
          else if (mode == MODE_SINGLE && in_pos_d && ss_level) begin
            state_q      <= ADIO_WAIT;
            stop_armed_q <= 1'b1;
          end else if (in_pos_d && mode != MODE_AUTO && mode != MODE_SINGLE) state_q <= ADIO_IDLE;
        end
        default: state_q <= ADIO_IDLE;
      endcase
    end
  end

  // stop and error reporting; set wins over command clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_max_decel <= 1'b0;
      brake_soft      <= 1'b0;
      job_abort       <= 1'b0;
      program_abort   <= 1'b0;
      follow_mode_end <= 1'b0;
      err_ext_stop    <= 1'b0;
      err_limit_start <= 1'b0;
      err_limit_end   <= 1'b0;
    end else begin
      brake_max_decel <= ext_stop_evt | lim_stop_evt;
      brake_soft      <= soft_limit_reached & motion_active;
      job_abort       <= ext_stop_evt | lim_stop_evt;
      program_abort   <= ext_stop_evt & (mode == MODE_AUTO || mode == MODE_SINGLE);
      follow_mode_end <= ss_rise & following;
      if (ext_stop_evt) err_ext_stop <= 1'b1;
      else if (cmd == CMD_START) err_ext_stop <= 1'b0;
      if (trip_neg) err_limit_start <= 1'b1;
      else if (cmd == CMD_START) err_limit_start <= 1'b0;
      if (trip_pos) err_limit_end <= 1'b1;
      else if (cmd == CMD_START) err_limit_end <= 1'b0;
    end
  end

  // digital outputs, active high, cleared while cpu stopped and cmd_output_disable_fitted set
  logic outs_off;
  assign outs_off = cpu_stopped & cmd_output_disable_fitted;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      axis_ready_output  <= 1'b0;
      in_position_output <= 1'b0;
      in_position_status <= 1'b0;
    end else begin
      axis_ready_output  <= startup_ok & machine_data_valid & ~outs_off;
      in_position_output <= in_pos_d & ~outs_off;
      in_position_status <= in_pos_d;
    end
  end
endmodule // adio_axis
`default_nettype wire

//--- common/adio_pkg.sv
// Function
// - axis ready low after power up
// - axis ready needs startup done, machine data
// - outputs forced low while cpu stopped; code forces them only when cmd_output_disable_fitted is also set
// - in position to status and pin
// - limits evaluated for any axis type
// - one parameter sets both limit polarities
// - limits act only while moving or following
// - limit trip brakes and aborts job
// - following mode trip only reports error
// - trip counts only toward moving direction
// - direction blocked until switch left opposite
// - precontact releases blocked direction, incremental variant
// - brake starts at software limit only
// - rising edge stops, falling edge starts
// - rising edge in job: error, end, brake
// - following mode stop edge restores control
// - input high holds checked job, waits
// - one held job; stop or start clears, CMD_OTHER refused
// - automatic mode waits at first statement
// - single statement mode waits after enter
// - raised after in position, waits falling edge
// - in position: setpoint at target, standstill
// - both outputs active high
`default_nettype none
package adio_pkg;
  localparam int unsigned SYS_CLK_HZ    = 25000000;
  localparam int unsigned SCAN_US       = 1000;
  localparam int unsigned SCAN_CYCLES   = SYS_CLK_HZ / 1000000 * SCAN_US;
  localparam int unsigned SCAN_W        = 15;
  localparam logic [3:0]  MODE_FOLLOW   = 4'h4;
  localparam logic [3:0]  MODE_AUTO     = 4'h8;
  localparam logic [3:0]  MODE_SINGLE   = 4'h9;
  localparam logic [2:0]  CMD_NONE      = 3'h0;
  localparam logic [2:0]  CMD_START     = 3'h1;
  localparam logic [2:0]  CMD_STOP      = 3'h2;
  localparam logic [2:0]  CMD_ENTER     = 3'h3;
  localparam logic [2:0]  CMD_OTHER     = 3'h4;
  localparam logic        POL_NC        = 1'b0;
  typedef enum logic [1:0] {ADIO_IDLE, ADIO_WAIT, ADIO_RUN} adio_state_t;
endpackage
`default_nettype wire

//--- sim/adio_far.sv
`default_nettype none
module adio_far (
  input  wire logic limit_polarity,
  input  wire logic trip_s,
  input  wire logic trip_e,
  input  wire logic ss_req,
  input  wire logic axis_ready_output,
  output logic      travel_start_limit_input,
  output logic      travel_end_limit_input,
  output logic      ext_start_stop_input,
  output logic      drive_en
);
  // a tripped contact reads as the polarity level
  assign travel_start_limit_input = trip_s ? limit_polarity : ~limit_polarity;
  assign travel_end_limit_input   = trip_e ? limit_polarity : ~limit_polarity;
  assign ext_start_stop_input     = ss_req;
  assign drive_en                 = axis_ready_output;
endmodule // adio_far
`default_nettype wire

//--- sim/adio_axis_assertions.sv
`default_nettype none
module adio_axis_chk
  import adio_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       startup_ok,
  input wire logic       cpu_stopped,
  input wire logic       cmd_output_disable_fitted,
  input wire logic       setpoint_at_target,
  input wire logic       in_standstill_window,
  input wire logic       soft_limit_reached,
  input wire logic [2:0] cmd,
  input wire logic       axis_ready_output,
  input wire logic       in_position_output,
  input wire logic       in_position_status,
  input wire logic       job_execute,
  input wire logic       job_abort,
  input wire logic       waiting_ext_start,
  input wire logic       err_ext_stop,
  input wire logic       err_inadmissible,
  input wire logic       brake_soft
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rst_low: assert property (!$past(rst_n) |-> !axis_ready_output && !job_execute) else $error("out after reset");
  a_rdy: assert property (!$past(startup_ok) |-> !axis_ready_output) else $error("ready early");
  a_cpu: assert property ($past(cpu_stopped && cmd_output_disable_fitted) |-> !axis_ready_output && !in_position_output)
    else $error("outputs not forced");
  a_pin: assert property (in_position_output |-> in_position_status) else $error("pin without status");
  a_inpos: assert property ($rose(in_position_status) |-> $past(setpoint_at_target && in_standstill_window))
    else $error("in position early");
  a_refuse: assert property (err_inadmissible |-> $past(cmd) == CMD_OTHER && $past(waiting_ext_start))
    else $error("bad refusal");
  a_stop: assert property ($past(cmd) == CMD_STOP |-> !waiting_ext_start) else $error("stop kept wait");
  a_wait: assert property ($rose(waiting_ext_start) |-> $past(cmd) == CMD_START || $past(cmd) == CMD_ENTER)
    else $error("wait without cmd");
  a_ext: assert property ($rose(err_ext_stop) |-> job_abort) else $error("stop without abort");
  a_soft: assert property (brake_soft |-> $past(soft_limit_reached)) else $error("soft brake early");
endmodule // adio_axis_chk
bind adio_axis adio_axis_chk u_chk (.*);
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top;
  import adio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, rst_n = 1'b0, startup_ok = 1'b0, machine_data_valid = 1'b0, cpu_stopped = 1'b0;
  logic       cmd_output_disable_fitted = 1'b1, limit_polarity = 1'b0, precontact_input = 1'b0;
  logic       incremental_variant = 1'b0, job_traversing = 1'b0, job_valid = 1'b0, motion_dir_pos = 1'b0;
  logic       motion_active = 1'b0, setpoint_at_target = 1'b0, in_standstill_window = 1'b0;
  logic       soft_limit_reached = 1'b0, trip_s = 1'b0, trip_e = 1'b0, ss_req = 1'b0, drive_en;
  logic [3:0] mode = 4'h1;
  logic [2:0] cmd = CMD_NONE;
  logic       travel_start_limit_input, travel_end_limit_input, ext_start_stop_input, axis_ready_output;
  logic       in_position_output, in_position_status, job_execute, brake_max_decel, brake_soft, job_abort;
  logic       program_abort, follow_mode_end, waiting_ext_start, err_limit_start, err_limit_end;
  logic       err_ext_stop, err_inadmissible, block_neg_dir, block_pos_dir;
  int         num_errors = 0, n_checks = 0, cyc_n = 0;
  adio_axis #(.SCAN_CYC(8)) u_dut (.*);
  adio_far u_far (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic seen, logic exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmdp(logic [2:0] c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= CMD_NONE;
    #1;
  endtask
  task automatic wfor(ref logic s, input string nm);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 60) begin
      cy(1);
      k++;
    end
    chk(nm, s, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_ready();
    chk("ready", axis_ready_output, 1'b0);
    startup_ok <= 1'b1;
    machine_data_valid <= 1'b1;
    setpoint_at_target <= 1'b1;
    in_standstill_window <= 1'b1;
    cy(3);
    chk("ready", axis_ready_output, 1'b1);
    chk("inpos_pin", in_position_output, 1'b1);
    chk("inpos_stat", in_position_status, 1'b1);
    chk("drive_en", drive_en, 1'b1);
    cpu_stopped <= 1'b1;
    cy(3);
    chk("ready", axis_ready_output, 1'b0);
    chk("inpos_pin", in_position_output, 1'b0);
    cpu_stopped <= 1'b0;
    setpoint_at_target <= 1'b0;
    $display("t_ready done");
  endtask
  task automatic t_ext();
    ss_req <= 1'b1;
    job_valid <= 1'b1;
    job_traversing <= 1'b1;
    cy(30);
    cmdp(CMD_START);
    chk("waiting", waiting_ext_start, 1'b1);
    cmdp(CMD_OTHER);
    chk("inadmissible", err_inadmissible, 1'b1);
    ss_req <= 1'b0;
    motion_active <= 1'b1;
    wfor(job_execute, "execute");
    chk("waiting", waiting_ext_start, 1'b0);
    ss_req <= 1'b1;
    wfor(err_ext_stop, "ext_stop");
    chk("job_abort", job_abort, 1'b1);
    chk("brake_max", brake_max_decel, 1'b1);
    motion_active <= 1'b0;
    cy(30);
    cmdp(CMD_START);
    chk("waiting", waiting_ext_start, 1'b1);
    cmdp(CMD_STOP);
    chk("waiting", waiting_ext_start, 1'b0);
    $display("t_ext done");
  endtask
  task automatic t_limit();
    for (int i = 0; i < 2; i++) begin
      // turn the direction first so a polarity swap reads as leaving the switch
      motion_dir_pos <= i[0];
      cy(2);
      limit_polarity <= i[0];
      ss_req <= 1'b0;
      cy(30);
      motion_active <= 1'b1;
      cy(1);
      cmdp(CMD_START);
      if (i == 1) trip_e <= 1'b1;
      else trip_s <= 1'b1;
      if (i == 1) wfor(err_limit_end, "lim_end");
      else wfor(err_limit_start, "lim_start");
      cy(4);
      chk("block_pos", block_pos_dir, i[0]);
      chk("block_neg", block_neg_dir, ~i[0]);
      motion_active <= 1'b0;
      trip_s <= 1'b0;
      trip_e <= 1'b0;
      cmdp(CMD_STOP);
    end
    $display("t_limit done");
  endtask
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    cy(1);
    t_ready();
    t_ext();
    t_limit();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
